/* File: include/cps_pkg.sv */
// Shared constants and carrier types for the CPU pointer and status registers
`default_nettype none
package cps_pkg;
  // Special function register addresses
  localparam logic [7:0] SFR_PTR0_LO = 8'h82;
  localparam logic [7:0] SFR_PTR0_HI = 8'h83;
  localparam logic [7:0] SFR_PTR1_LO = 8'h84;
  localparam logic [7:0] SFR_PTR1_HI = 8'h85;
  localparam logic [7:0] SFR_PTR_SEL = 8'h92;
  localparam logic [7:0] SFR_STATUS = 8'hd0;
  localparam logic [7:0] SFR_ACCUM = 8'he0;
  // Bit address of status bit 0, bits follow upward
  localparam logic [7:0] BIT_STATUS_BASE = 8'hd0;
  // Status word field positions
  localparam int ST_CARRY = 7;
  localparam int ST_HALF = 6;
  localparam int ST_USER0 = 5;
  localparam int ST_BANK_HI = 4;
  localparam int ST_BANK_LO = 3;
  localparam int ST_RANGE = 2;
  localparam int ST_USER1 = 1;
  localparam int ST_P = 0;
  localparam int PTR_SEL_BIT = 0;
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_PTR = 16'h0000;
  // Bank windows in DATA and unified space
  localparam logic [15:0] DATA_BANK_BASE = 16'h0000;
  localparam logic [15:0] UNI_BANK_BASE = 16'hff00;
  localparam int GPR_AW = 5;
  localparam int GPR_WORDS = 32;

  // One access from the datapath or the SFR bus
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } cps_mem_req_t;

  // Single-bit write through bit addressing
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic val;
  } cps_bit_req_t;

  // Flag results of one arithmetic operation
  typedef struct packed {
    logic en_carry;
    logic en_half;
    logic en_range;
    logic carry;
    logic half;
    logic range;
  } cps_flag_upd_t;
endpackage : cps_pkg
`default_nettype wire

/* File: rtl/cps_bank_ram.sv */
// Storage for the four banks of eight general registers
`default_nettype none
module cps_bank_ram (
  // Clock
  input wire logic sys_clk,
  // Single access port
  input wire logic we,
  input wire logic [cps_pkg::GPR_AW-1:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata_q
);
  logic [7:0] mem_q [cps_pkg::GPR_WORDS];

  // Contents are not cleared by reset, like plain RAM
  always_ff @(posedge sys_clk) begin
    if (we) begin
      mem_q[addr] <= wdata;
    end
  end

  // Read returns the old word on a same-cycle write
  always_ff @(posedge sys_clk) begin
    rdata_q <= mem_q[addr];
  end
endmodule : cps_bank_ram
`default_nettype wire

/* File: rtl/cps_regs.sv */
// Data pointers, register banks, accumulator and status word of the CPU
`default_nettype none
module cps_regs (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // SFR byte bus
  input wire cps_pkg::cps_mem_req_t sfr_req,
  output logic [7:0] sfr_rdata_q,
  // SFR bit writes
  input wire cps_pkg::cps_bit_req_t bit_req,
  // Datapath writes
  input wire logic accum_wr,
  input wire logic [7:0] accum_wdata,
  input wire logic dptr_wr,
  input wire logic [15:0] dptr_wdata,
  input wire cps_pkg::cps_flag_upd_t flag_upd,
  // General register accesses, priority in this order
  input wire cps_pkg::cps_mem_req_t rn_req,
  input wire cps_pkg::cps_mem_req_t data_req,
  input wire cps_pkg::cps_mem_req_t uni_req,
  output logic [7:0] gpr_rdata,
  output logic gpr_rvalid_q,
  // Architectural state
  output logic [7:0] accum_q,
  output logic [7:0] status_q,
  output logic [15:0] active_ptr_q
);
  logic [15:0] ptr_q [2];
  logic [15:0] ptr_d [2];
  logic sel_q;
  logic sel_d;
  logic [7:0] accum_d;
  logic [7:0] status_d;
  logic [7:0] sfr_rd_d;
  logic sfr_wr_status;
  logic bit_wr_status;
  logic data_hit;
  logic uni_hit;
  logic gpr_we;
  logic gpr_act;
  logic [cps_pkg::GPR_AW-1:0] gpr_addr;
  logic [7:0] gpr_wdata;

  // True when addr falls in the 32-byte bank window at base
  function automatic logic in_window(input logic [15:0] addr, input logic [15:0] base);
    logic [15:0] off;
    off = addr - base;
    in_window = (off[15:cps_pkg::GPR_AW] == '0);
  endfunction : in_window

  // True for an SFR write to the given address
  function automatic logic sfr_wr_to(input cps_pkg::cps_mem_req_t r, input logic [7:0] a);
    sfr_wr_to = r.wr && (r.addr[7:0] == a);
  endfunction : sfr_wr_to

  assign sfr_wr_status = sfr_wr_to(sfr_req, cps_pkg::SFR_STATUS);
  assign bit_wr_status = bit_req.wr && (bit_req.addr[7:3] == cps_pkg::BIT_STATUS_BASE[7:3]);

  // Pointer next state; SFR byte writes land after the datapath write
  always_comb begin
    ptr_d[0] = ptr_q[0];
    ptr_d[1] = ptr_q[1];
    if (dptr_wr) begin
      ptr_d[sel_q] = dptr_wdata;
    end
    if (sfr_wr_to(sfr_req, cps_pkg::SFR_PTR0_LO)) begin
      ptr_d[0][7:0] = sfr_req.wdata;
    end
    if (sfr_wr_to(sfr_req, cps_pkg::SFR_PTR0_HI)) begin
      ptr_d[0][15:8] = sfr_req.wdata;
    end
    if (sfr_wr_to(sfr_req, cps_pkg::SFR_PTR1_LO)) begin
      ptr_d[1][7:0] = sfr_req.wdata;
    end
    if (sfr_wr_to(sfr_req, cps_pkg::SFR_PTR1_HI)) begin
      ptr_d[1][15:8] = sfr_req.wdata;
    end
  end

  // Only bit 0 of the select register is kept
  always_comb begin
    sel_d = sel_q;
    if (sfr_wr_to(sfr_req, cps_pkg::SFR_PTR_SEL)) begin
      sel_d = sfr_req.wdata[cps_pkg::PTR_SEL_BIT];
    end
  end

  // Pointer registers
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ptr_q[0] <= cps_pkg::RST_PTR;
      ptr_q[1] <= cps_pkg::RST_PTR;
      sel_q <= 1'b0;
    end else begin
      ptr_q[0] <= ptr_d[0];
      ptr_q[1] <= ptr_d[1];
      sel_q <= sel_d;
    end
  end

  // Registered copy of the chosen pointer keeps the output glitch free
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      active_ptr_q <= cps_pkg::RST_PTR;
    end else begin
      active_ptr_q <= ptr_d[sel_d];
    end
  end

  // Accumulator, SFR write wins over the datapath
  always_comb begin
    accum_d = accum_q;
    if (accum_wr) begin
      accum_d = accum_wdata;
    end
    if (sfr_wr_to(sfr_req, cps_pkg::SFR_ACCUM)) begin
      accum_d = sfr_req.wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      accum_q <= cps_pkg::RST_BYTE;
    end else begin
      accum_q <= accum_d;
    end
  end

  // Status word: flags first, then software writes, parity always last
  always_comb begin
    status_d = status_q;
    if (flag_upd.en_carry) begin
      status_d[cps_pkg::ST_CARRY] = flag_upd.carry;
    end
    if (flag_upd.en_half) begin
      status_d[cps_pkg::ST_HALF] = flag_upd.half;
    end
    if (flag_upd.en_range) begin
      status_d[cps_pkg::ST_RANGE] = flag_upd.range;
    end
    // User flags change only through these two software paths
    if (sfr_wr_status) begin
      status_d = sfr_req.wdata;
    end
    if (bit_wr_status) begin
      status_d[bit_req.addr[2:0]] = bit_req.val;
    end
    // Parity cannot be written, it tracks the new accumulator value
    status_d[cps_pkg::ST_P] = ^accum_d;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      status_q <= cps_pkg::RST_BYTE;
    end else begin
      status_q <= status_d;
    end
  end

  // SFR read mux, unmapped addresses read zero
  always_comb begin
    sfr_rd_d = 8'h00;
    case (sfr_req.addr[7:0])
      cps_pkg::SFR_PTR0_LO: sfr_rd_d = ptr_q[0][7:0];
      cps_pkg::SFR_PTR0_HI: sfr_rd_d = ptr_q[0][15:8];
      cps_pkg::SFR_PTR1_LO: sfr_rd_d = ptr_q[1][7:0];
      cps_pkg::SFR_PTR1_HI: sfr_rd_d = ptr_q[1][15:8];
      cps_pkg::SFR_PTR_SEL: sfr_rd_d = {7'h00, sel_q};
      cps_pkg::SFR_STATUS: sfr_rd_d = status_q;
      cps_pkg::SFR_ACCUM: sfr_rd_d = accum_q;
      default: sfr_rd_d = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sfr_rdata_q <= cps_pkg::RST_BYTE;
    end else if (sfr_req.rd) begin
      sfr_rdata_q <= sfr_rd_d;
    end
  end

  // Bank access arbitration; one port means a losing request is dropped
  assign data_hit = in_window({8'h00, data_req.addr[7:0]}, cps_pkg::DATA_BANK_BASE);
  assign uni_hit = in_window(uni_req.addr, cps_pkg::UNI_BANK_BASE);
  always_comb begin
    gpr_act = 1'b0;
    gpr_we = 1'b0;
    gpr_addr = '0;
    gpr_wdata = 8'h00;
    if (rn_req.wr || rn_req.rd) begin
      gpr_act = 1'b1;
      gpr_we = rn_req.wr;
      gpr_addr = {status_q[cps_pkg::ST_BANK_HI:cps_pkg::ST_BANK_LO], rn_req.addr[2:0]};
      gpr_wdata = rn_req.wdata;
    end else if ((data_req.wr || data_req.rd) && data_hit) begin
      gpr_act = 1'b1;
      gpr_we = data_req.wr;
      gpr_addr = data_req.addr[cps_pkg::GPR_AW-1:0];
      gpr_wdata = data_req.wdata;
    end else if ((uni_req.wr || uni_req.rd) && uni_hit) begin
      gpr_act = 1'b1;
      gpr_we = uni_req.wr;
      gpr_addr = uni_req.addr[cps_pkg::GPR_AW-1:0];
      gpr_wdata = uni_req.wdata;
    end
  end

  cps_bank_ram u_bank (
    .sys_clk(sys_clk),
    .we(gpr_we),
    .addr(gpr_addr),
    .wdata(gpr_wdata),
    .rdata_q(gpr_rdata)
  );

  // Read data from the bank is valid the cycle after a read that wins arbitration and hits its window
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      gpr_rvalid_q <= 1'b0;
    end else begin
      gpr_rvalid_q <= gpr_act && !gpr_we;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  property p_active_ptr;
    active_ptr_q == (sel_q ? ptr_q[1] : ptr_q[0]);
  endproperty
  a_active_ptr: assert property (p_active_ptr) else $error("active pointer mismatch");

  property p_reset_vals;
    $past(srst) |-> (ptr_q[0] == 16'h0000) && (ptr_q[1] == 16'h0000) && !sel_q && (status_q == 8'h00);
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset value wrong");

  property p_bank_zero_reset;
    $past(srst) |-> status_q[4:3] == 2'b00 && accum_q == 8'h00;
  endproperty
  a_bank_zero_reset: assert property (p_bank_zero_reset) else $error("bank or acc not reset");

  property p_parity;
    status_q[0] == ^accum_q;
  endproperty
  a_parity: assert property (p_parity) else $error("parity wrong");

  property p_carry;
    flag_upd.en_carry && !sfr_wr_status && !bit_wr_status |=> status_q[7] == $past(flag_upd.carry);
  endproperty
  a_carry: assert property (p_carry) else $error("carry not updated");

  property p_half;
    flag_upd.en_half && !sfr_wr_status && !bit_wr_status |=> status_q[6] == $past(flag_upd.half);
  endproperty
  a_half: assert property (p_half) else $error("half carry not updated");

  property p_ovf;
    flag_upd.en_range && !sfr_wr_status && !bit_wr_status |=> status_q[2] == $past(flag_upd.range);
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow not updated");

  property p_user_flags;
    !sfr_wr_status && !bit_wr_status |=> $stable(status_q[5]) && $stable(status_q[1]);
  endproperty
  a_user_flags: assert property (p_user_flags) else $error("user flag changed");

  property p_bit_wr;
    bit_req.wr && bit_req.addr == 8'hd5 && !sfr_wr_status |=> status_q[5] == $past(bit_req.val);
  endproperty
  a_bit_wr: assert property (p_bit_wr) else $error("bit write lost");

  property p_ptr_hi;
    sfr_req.wr && sfr_req.addr[7:0] == 8'h83 |=> ptr_q[0][15:8] == $past(sfr_req.wdata);
  endproperty
  a_ptr_hi: assert property (p_ptr_hi) else $error("pointer high byte write lost");

  property p_accum_wr;
    accum_wr && !(sfr_req.wr && sfr_req.addr[7:0] == 8'he0) |=> accum_q == $past(accum_wdata);
  endproperty
  a_accum_wr: assert property (p_accum_wr) else $error("accumulator write lost");

  property p_rn_bank;
    (rn_req.wr || rn_req.rd) |-> gpr_addr == {status_q[4:3], rn_req.addr[2:0]};
  endproperty
  a_rn_bank: assert property (p_rn_bank) else $error("Rn bank wrong");

  property p_uni_map;
    !(rn_req.wr || rn_req.rd) && !data_req.wr && !data_req.rd && uni_req.wr && uni_req.addr == 16'hff1f
      |-> gpr_we && gpr_addr == 5'h1f;
  endproperty
  a_uni_map: assert property (p_uni_map) else $error("unified map wrong");

  property p_data_map;
    !(rn_req.wr || rn_req.rd) && data_req.wr && data_req.addr[7:0] == 8'h08 |-> gpr_we && gpr_addr == 5'h08;
  endproperty
  a_data_map: assert property (p_data_map) else $error("data map wrong");

  c_sel_one: cover property (sel_q && dptr_wr);
  c_bank3: cover property (status_q[4:3] == 2'b11 ##1 rn_req.wr);
  c_flag_and_sfr: cover property (flag_upd.en_carry && sfr_wr_status);
endmodule : cps_regs
`default_nettype wire

/* File: testbench/cps_core_model.sv */
// Core datapath and SFR bus model that drives the register block
`default_nettype none
module cps_core_model (
  // Clock
  input wire logic sys_clk,
  // Requests towards the registers
  output var cps_pkg::cps_mem_req_t sfr_req,
  output var cps_pkg::cps_bit_req_t bit_req,
  output var logic accum_wr,
  output var logic [7:0] accum_wdata,
  output var logic dptr_wr,
  output var logic [15:0] dptr_wdata,
  output var cps_pkg::cps_flag_upd_t flag_upd,
  output var cps_pkg::cps_mem_req_t rn_req,
  output var cps_pkg::cps_mem_req_t data_req,
  output var cps_pkg::cps_mem_req_t uni_req,
  // Answers from the registers
  input wire logic [7:0] sfr_rdata_q,
  input wire logic [7:0] gpr_rdata,
  input wire logic gpr_rvalid_q
);
  timeunit 1ns;
  timeprecision 100ps;

  // Drop every request; data fields go to zero with their strobes
  task automatic clear();
    sfr_req = '0;
    bit_req = '0;
    accum_wr = 1'b0;
    accum_wdata = 8'h00;
    dptr_wr = 1'b0;
    dptr_wdata = 16'h0000;
    flag_upd = '0;
    rn_req = '0;
    data_req = '0;
    uni_req = '0;
  endtask : clear

  // Move just past the next rising edge, so requests never race it
  task automatic step();
    @(posedge sys_clk);
    #1;
  endtask : step

  // Idle cycle between requests keeps each strobe to one change per step
  task automatic idle();
    clear();
    step();
  endtask : idle

  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    sfr_req = '{wr: 1'b1, rd: 1'b0, addr: {8'h00, a}, wdata: d};
    step();
    idle();
  endtask : sfr_wr

  task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
    sfr_req = '{wr: 1'b0, rd: 1'b1, addr: {8'h00, a}, wdata: 8'h00};
    step();
    d = sfr_rdata_q;
    idle();
  endtask : sfr_rd

  task automatic bit_w(input logic [7:0] a, input logic v);
    bit_req = '{wr: 1'b1, addr: a, val: v};
    step();
    idle();
  endtask : bit_w

  task automatic accum_w(input logic [7:0] d);
    accum_wr = 1'b1;
    accum_wdata = d;
    step();
    idle();
  endtask : accum_w

  task automatic dptr_w(input logic [15:0] d);
    dptr_wr = 1'b1;
    dptr_wdata = d;
    step();
    idle();
  endtask : dptr_w

  task automatic flag_w(input cps_pkg::cps_flag_upd_t f);
    flag_upd = f;
    step();
    idle();
  endtask : flag_w

  // Port 0 register operand, 1 DATA, 2 unified
  task automatic bank(input int k, input logic w, input logic [15:0] a, input logic [7:0] d,
                      output logic [7:0] q, output logic v);
    cps_pkg::cps_mem_req_t r;
    r = '{wr: w, rd: ~w, addr: a, wdata: d};
    case (k)
      0: rn_req = r;
      1: data_req = r;
      default: uni_req = r;
    endcase
    step();
    q = gpr_rdata;
    v = gpr_rvalid_q;
    idle();
  endtask : bank

  initial begin
    clear();
  end
endmodule : cps_core_model
`default_nettype wire

/* File: testbench/testbench.sv */
// Self-checking bench for the CPU pointer and status registers
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk;
  logic srst;
  cps_pkg::cps_mem_req_t sfr_req, rn_req, data_req, uni_req;
  cps_pkg::cps_bit_req_t bit_req;
  cps_pkg::cps_flag_upd_t flag_upd;
  logic accum_wr, dptr_wr, gpr_rvalid_q, v;
  logic [7:0] accum_wdata, sfr_rdata_q, gpr_rdata, accum_q, status_q, rd;
  logic [15:0] dptr_wdata, active_ptr_q;
  logic [7:0] vals[7] = '{8'h00, 8'h01, 8'h03, 8'h07, 8'h80, 8'hff, 8'h5a};
  logic [7:0] regs[8] = '{8'h82, 8'h83, 8'h84, 8'h85, 8'h92, 8'hd0, 8'he0, 8'h81};
  int fpos[3] = '{7, 6, 2};
  int error_cnt;
  int checks;

  cps_regs dut_u (.sys_clk(sys_clk), .srst(srst), .sfr_req(sfr_req), .sfr_rdata_q(sfr_rdata_q),
    .bit_req(bit_req), .accum_wr(accum_wr), .accum_wdata(accum_wdata), .dptr_wr(dptr_wr),
    .dptr_wdata(dptr_wdata), .flag_upd(flag_upd), .rn_req(rn_req), .data_req(data_req),
    .uni_req(uni_req), .gpr_rdata(gpr_rdata), .gpr_rvalid_q(gpr_rvalid_q), .accum_q(accum_q),
    .status_q(status_q), .active_ptr_q(active_ptr_q));

  cps_core_model model_u (.sys_clk(sys_clk), .sfr_req(sfr_req), .bit_req(bit_req), .accum_wr(accum_wr),
    .accum_wdata(accum_wdata), .dptr_wr(dptr_wr), .dptr_wdata(dptr_wdata), .flag_upd(flag_upd),
    .rn_req(rn_req), .data_req(data_req), .uni_req(uni_req), .sfr_rdata_q(sfr_rdata_q),
    .gpr_rdata(gpr_rdata), .gpr_rvalid_q(gpr_rvalid_q));

  // 50 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // Case inequality so an unknown never counts as a match
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    model_u.sfr_rd(a, rd);
    chk("sfr read", {8'h00, rd}, {8'h00, exp});
  endtask : rd_chk

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test

  // Watchdog against a hung sequence
  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    end_of_test();
  end

  initial begin
    error_cnt = 0;
    checks = 0;
    srst = 1'b1;
    repeat (6) @(posedge sys_clk);
    #1;
    srst = 1'b0;
    // Reset values, unmapped 0x81 included
    foreach (regs[i]) rd_chk(regs[i], 8'h00);
    chk("status", {8'h00, status_q}, 16'h0000);
    chk("pointer", active_ptr_q, 16'h0000);
    $display("test reset done");
    // Pointer bytes and selection
    model_u.sfr_wr(8'h82, 8'h34);
    model_u.sfr_wr(8'h83, 8'h12);
    model_u.sfr_wr(8'h84, 8'h78);
    model_u.sfr_wr(8'h85, 8'h56);
    chk("pointer", active_ptr_q, 16'h1234);
    rd_chk(8'h85, 8'h56);
    model_u.sfr_wr(8'h92, 8'hff);
    chk("pointer", active_ptr_q, 16'h5678);
    rd_chk(8'h92, 8'h01);
    model_u.dptr_w(16'hbeef);
    chk("pointer", active_ptr_q, 16'hbeef);
    rd_chk(8'h84, 8'hef);
    rd_chk(8'h82, 8'h34);
    model_u.sfr_wr(8'h92, 8'h00);
    chk("pointer", active_ptr_q, 16'h1234);
    // Datapath write with pointer zero chosen leaves pointer one alone
    model_u.dptr_w(16'hcafe);
    chk("pointer", active_ptr_q, 16'hcafe);
    rd_chk(8'h83, 8'hca);
    rd_chk(8'h85, 8'hbe);
    $display("test pointers done");
    // Accumulator and parity
    foreach (vals[i]) begin
      model_u.accum_w(vals[i]);
      chk("accumulator", {8'h00, accum_q}, {8'h00, vals[i]});
      chk("parity", {15'h0000, status_q[0]}, {15'h0000, ^vals[i]});
    end
    model_u.sfr_wr(8'he0, 8'h0e);
    rd_chk(8'he0, 8'h0e);
    chk("parity", {15'h0000, status_q[0]}, 16'h0001);
    $display("test accumulator done");
    // Arithmetic flags set then cleared, one enable at a time
    for (int i = 0; i < 3; i++) begin
      model_u.flag_w(6'b100100 >> i);
      chk("flag set", {15'h0000, status_q[fpos[i]]}, 16'h0001);
      model_u.flag_w(6'b100000 >> i);
      chk("flag clear", {15'h0000, status_q[fpos[i]]}, 16'h0000);
    end
    model_u.bit_w(8'hd5, 1'b1);
    model_u.bit_w(8'hd1, 1'b1);
    model_u.bit_w(8'hd7, 1'b1);
    chk("status", {8'h00, status_q}, 16'h00a3);
    model_u.flag_w(6'b111000);
    model_u.bit_w(8'hd0, 1'b0);
    chk("status", {8'h00, status_q}, 16'h0023);
    $display("test status done");
    // Banks through DATA, read back through unified space
    for (int a = 0; a < 32; a++) model_u.bank(1, 1'b1, 16'(a), 8'(a) ^ 8'ha5, rd, v);
    for (int a = 0; a < 32; a++) begin
      model_u.bank(2, 1'b0, 16'hff00 + 16'(a), 8'h00, rd, v);
      chk("unified read", {7'h00, v, rd}, {8'h01, 8'(a) ^ 8'ha5});
    end
    for (int b = 0; b < 4; b++) begin
      model_u.sfr_wr(8'hd0, 8'(b) << 3);
      chk("bank field", {14'h0000, status_q[4:3]}, 16'(b));
      model_u.bank(0, 1'b0, 16'h0005, 8'h00, rd, v);
      chk("operand read", {7'h00, v, rd}, {8'h01, 8'(b * 8 + 5) ^ 8'ha5});
    end
    model_u.bank(0, 1'b1, 16'h0002, 8'h3c, rd, v);
    model_u.bank(1, 1'b0, 16'h001a, 8'h00, rd, v);
    chk("operand write", {7'h00, v, rd}, 16'h013c);
    model_u.bank(1, 1'b0, 16'h0020, 8'h00, rd, v);
    chk("data window", {15'h0000, v}, 16'h0000);
    model_u.bank(2, 1'b0, 16'hff20, 8'h00, rd, v);
    chk("unified window", {15'h0000, v}, 16'h0000);
    // Unified write to the top word, read back as R7 of bank 3
    model_u.bank(2, 1'b1, 16'hff1f, 8'hc3, rd, v);
    model_u.bank(0, 1'b0, 16'h0007, 8'h00, rd, v);
    chk("unified write", {7'h00, v, rd}, 16'h01c3);
    $display("test banks done");
    // Reset in mid-run returns every SFR to zero
    srst = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    srst = 1'b0;
    foreach (regs[i]) rd_chk(regs[i], 8'h00);
    chk("pointer", active_ptr_q, 16'h0000);
    $display("test mid-run reset done");
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
